// File: core/smcb_bank.sv
// smcb_bank: sync, options, pin override and bus address command bank
// assumes: a bus front end hands over whole decoded commands, one per pulse;
// RESET_I is the power-on reset; nvm and pin values are stable at release
`timescale 1ns/1ps
`include "smcb_regs.svh"
module smcb_bank (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic        CMD_WRITE_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [47:0] CMD_DATA_I,
  input  wire logic        CMD_PEC_I,
  output logic             CMD_ACK_O,
  output logic             CMD_NACK_O,
  output logic      [63:0] CMD_RDATA_O,
  input  wire logic        CONVERTING_I,
  input  wire logic        STATUS_CLR_I,
  input  wire logic [47:0] NVM_SYNC_I,
  input  wire logic [39:0] NVM_MISC_I,
  input  wire logic [7:0]  NVM_OVR_I,
  input  wire logic [6:0]  NVM_ADDR_I,
  input  wire logic [7:0]  NVM_VBOOT_A_I,
  input  wire logic [7:0]  NVM_PHASE_CFG_I,
  input  wire logic [6:0]  PIN_ADDR_I,
  input  wire logic [7:0]  PIN_VBOOT_A_I,
  input  wire logic [7:0]  PIN_PHASE_CFG_I,
  input  wire logic        LOG_WE_I,
  input  wire logic [63:0] LOG_DATA_I,
  input  wire logic [1:0]  SOFT_START_I,
  output logic      [47:0] SYNC_STORE_O,
  output logic      [6:0]  ADDR_STORE_O,
  output logic      [6:0]  ACTIVE_ADDR_O,
  output logic      [7:0]  VBOOT_A_O,
  output logic      [7:0]  PHASE_CFG_O,
  output logic      [1:0]  LOCK_LOOP_ON_O,
  output logic      [1:0]  FREQ_LOOP_ON_O,
  output logic             FREQ_LOOP_GAIN_HALF_A_O,
  output logic             SYNC_OUT_FROM_B_O,
  output logic      [1:0]  SYNC_CLOCK_INTERNAL_O,
  output logic      [8:0]  PHASE_OFFSET_DEG_A_O,
  output logic      [8:0]  PHASE_OFFSET_DEG_B_O,
  output logic      [1:0]  DCM_ALL_O,
  output logic      [1:0]  DCM_PHASE0_O,
  output logic             IIN_CALC_REPORT_O,
  output logic             IIN_CALC_FAULT_EN_O,
  output logic             IIN_USE_A_O,
  output logic             IIN_USE_B_O,
  output logic      [1:0]  DOWN_SLEW_SHIFT_A_O,
  output logic      [1:0]  DOWN_SLEW_SHIFT_B_O,
  output logic             FORCE_CHECK_BYTE_O,
  output logic             BOOT_TARGET_AFTER_SHUTDOWN_O,
  output logic             TRIM_RANGE_EXTEND_O,
  output logic      [3:0]  OP_INIT_A_O,
  output logic      [3:0]  OP_INIT_B_O,
  output logic             DATA_FAULT_O,
  output logic             NO_UPDATE_O,
  output logic             ALERT_O
);
  localparam int LOG_AW = 5;

  smcb_pkg::smcb_state_t state_q;
  logic [47:0]       sync_q;
  logic [47:0]       sync_act_q;
  logic [39:0]       misc_q;
  logic [7:0]        ovr_q;
  logic [6:0]        addr_q;
  logic [6:0]        addr_act_q;
  logic [7:0]        vboot_q;
  logic [7:0]        phase_cfg_q;
  logic              ack_q;
  logic              nack_q;
  logic [63:0]       rdata_q;
  logic              data_fault_q;
  logic              no_update_q;
  logic [LOG_AW-1:0] log_wptr_q;
  logic [63:0]       log_rdata;
  logic              take;
  logic              known;
  logic              pec_miss;
  logic              ro_write;
  logic              sync_wr;
  logic              sync_locked;
  logic              sync_bad;
  logic              refuse;

  function automatic logic sync_valid(input logic [47:0] v);
    sync_valid = (v[`SMCB_S_PHASE_A +: 4] <= `SMCB_PHASE_MAX)
              && (v[`SMCB_S_PHASE_B +: 4] <= `SMCB_PHASE_MAX)
              && (v[`SMCB_S_PWMDIV_A +: 4] <= `SMCB_PWMDIV_MAX)
              && (v[`SMCB_S_PWMDIV_B +: 4] <= `SMCB_PWMDIV_MAX)
              && (v[`SMCB_S_INDIV +: 6] <= `SMCB_INDIV_MAX)
              && (v[`SMCB_S_SCALAR_A +: 3] != `SMCB_SCALAR_BAD)
              && (v[`SMCB_S_SCALAR_B +: 3] != `SMCB_SCALAR_BAD);
  endfunction

  // commands arriving in the power-on load cycle are dropped unanswered
  assign take     = CMD_VALID_I && (state_q == smcb_pkg::ST_RUN);
  assign known    = (CMD_CODE_I == `SMCB_CMD_LOG)
                 || (CMD_CODE_I == `SMCB_CMD_SYNC)
                 || (CMD_CODE_I == `SMCB_CMD_MISC)
                 || (CMD_CODE_I == `SMCB_CMD_OVR)
                 || (CMD_CODE_I == `SMCB_CMD_ADDR);
  assign pec_miss = misc_q[`SMCB_M_CHECK_BYTE] && !CMD_PEC_I;
  assign ro_write = CMD_WRITE_I && (CMD_CODE_I == `SMCB_CMD_LOG);
  assign sync_wr  = CMD_WRITE_I && (CMD_CODE_I == `SMCB_CMD_SYNC);
  assign sync_locked = sync_wr && CONVERTING_I;
  assign sync_bad = sync_wr && !sync_valid(CMD_DATA_I);
  assign refuse   = !known || pec_miss || ro_write || sync_locked
                 || sync_bad;

  // power-on sequencing: one load cycle after reset release
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_q <= smcb_pkg::ST_LOAD;
    end else begin
      case (state_q)
        smcb_pkg::ST_LOAD: state_q <= smcb_pkg::ST_RUN;
        smcb_pkg::ST_RUN:  state_q <= smcb_pkg::ST_RUN;
        default:           state_q <= smcb_pkg::ST_LOAD;
      endcase
    end
  end

  // pin detection happens only in the load cycle, never on later override writes
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      addr_act_q  <= '0;
      vboot_q     <= '0;
      phase_cfg_q <= '0;
    end else if (state_q == smcb_pkg::ST_LOAD) begin
      addr_act_q  <= NVM_OVR_I[`SMCB_O_ADDR] ? PIN_ADDR_I
                                             : NVM_ADDR_I;
      vboot_q     <= NVM_OVR_I[`SMCB_O_BOOT] ? PIN_VBOOT_A_I
                                             : NVM_VBOOT_A_I;
      phase_cfg_q <= NVM_OVR_I[`SMCB_O_PHASE] ? PIN_PHASE_CFG_I
                                              : NVM_PHASE_CFG_I;
    end
  end

  // written sync image waits for a store and power cycle to act
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync_q     <= '0;
      sync_act_q <= '0;
    end else if (state_q == smcb_pkg::ST_LOAD) begin
      sync_q     <= NVM_SYNC_I & `SMCB_SYNC_MASK;
      sync_act_q <= NVM_SYNC_I & `SMCB_SYNC_MASK;
    end else if (take && sync_wr && !refuse) begin
      sync_q     <= CMD_DATA_I & `SMCB_SYNC_MASK;
    end
  end

  // options apply on the fly
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      misc_q <= '0;
    end else if (state_q == smcb_pkg::ST_LOAD) begin
      misc_q <= NVM_MISC_I & `SMCB_MISC_MASK;
      misc_q[`SMCB_M_LOG_READ_OFFSET +: 5] <= '0;
    end else if (take && CMD_WRITE_I && !refuse
                 && CMD_CODE_I == `SMCB_CMD_MISC) begin
      misc_q <= CMD_DATA_I[39:0] & `SMCB_MISC_MASK;
    end
  end

  // override and address writes keep nvm images; pins already sampled
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ovr_q  <= '0;
      addr_q <= '0;
    end else if (state_q == smcb_pkg::ST_LOAD) begin
      ovr_q  <= NVM_OVR_I & `SMCB_OVR_MASK;
      addr_q <= NVM_OVR_I[`SMCB_O_ADDR] ? PIN_ADDR_I
                                        : NVM_ADDR_I;
    end else if (take && CMD_WRITE_I && !refuse) begin
      if (CMD_CODE_I == `SMCB_CMD_OVR) begin
        ovr_q <= CMD_DATA_I[7:0] & `SMCB_OVR_MASK;
      end
      if (CMD_CODE_I == `SMCB_CMD_ADDR) begin
        addr_q <= CMD_DATA_I[6:0] & `SMCB_ADDR_MASK;
      end
    end
  end

  // answer one cycle after the request
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q  <= take && !refuse;
      nack_q <= take && refuse;
      if (take && !refuse && !CMD_WRITE_I) begin
        case (CMD_CODE_I)
          `SMCB_CMD_LOG:  rdata_q <= log_rdata;
          `SMCB_CMD_SYNC: rdata_q <= {16'h0000, sync_q};
          `SMCB_CMD_MISC: rdata_q <= {24'h00_0000, misc_q};
          `SMCB_CMD_OVR:  rdata_q <= {56'h0, ovr_q};
          `SMCB_CMD_ADDR: rdata_q <= {57'h0, addr_q};
          default:        rdata_q <= '0;
        endcase
      end
    end
  end

  // sticky status; a new event in the clear cycle wins over the clear
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      data_fault_q <= 1'b0;
      no_update_q  <= 1'b0;
    end else begin
      data_fault_q <= (take && sync_bad && !sync_locked)
                   || (data_fault_q && !STATUS_CLR_I);
      no_update_q  <= (take && sync_locked)
                   || (no_update_q && !STATUS_CLR_I);
    end
  end

  // log write pointer wraps over the 32 entries
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      log_wptr_q <= '0;
    end else if (LOG_WE_I) begin
      log_wptr_q <= log_wptr_q + 5'h01;
    end
  end

  smcb_log_mem #(
    .DEPTH (`SMCB_LOG_DEPTH),
    .WIDTH (`SMCB_LOG_WIDTH),
    .AW    (LOG_AW)
  ) u_log (
    .CLK_I   (CLK_I),
    .RESET_I (RESET_I),
    .WE_I    (LOG_WE_I),
    .WADDR_I (log_wptr_q),
    .WDATA_I (LOG_DATA_I),
    .RADDR_I (misc_q[`SMCB_M_LOG_READ_OFFSET +: 5]),
    .RDATA_O (log_rdata)
  );

  // per-channel decode, index 0 is channel A
  logic [1:0]                     ll_code [2];
  logic [3:0]                     ph_code [2];
  logic [8:0]                     ph_deg  [2];
  logic [1:0]                     vsrc    [2];
  logic [3:0]                     op_init [2];
  assign ll_code[0] = misc_q[`SMCB_M_LL_A +: 2];
  assign ll_code[1] = misc_q[`SMCB_M_LL_B +: 2];
  assign ph_code[0] = sync_act_q[`SMCB_S_PHASE_A +: 4];
  assign ph_code[1] = sync_act_q[`SMCB_S_PHASE_B +: 4];
  assign vsrc[0]    = misc_q[`SMCB_M_VSRC_A +: 2];
  assign vsrc[1]    = misc_q[`SMCB_M_VSRC_B +: 2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    smcb_pkg::smcb_light_load_t mode;
    assign mode = smcb_pkg::smcb_light_load_t'(ll_code[ch]);
    assign DCM_ALL_O[ch] = (mode == smcb_pkg::LL_ALL_AUTO)
                        || (mode == smcb_pkg::LL_SOFTSTART_AUTO
                            && SOFT_START_I[ch]);
    assign DCM_PHASE0_O[ch] = (mode != smcb_pkg::LL_FORCED_CONT)
                           && !(mode == smcb_pkg::LL_SOFTSTART_AUTO
                                && !SOFT_START_I[ch]);
    // reserved codes fall back to zero shift rather than wrap past 360
    assign ph_deg[ch] = (ph_code[ch] <= `SMCB_PHASE_MAX)
                      ? 9'(ph_code[ch] * `SMCB_PHASE_STEP)
                      : 9'h000;
    assign op_init[ch] = vsrc[ch][1] ? `SMCB_OP_INIT_HI
                                     : `SMCB_OP_INIT_LO;
  end

  assign PHASE_OFFSET_DEG_A_O = ph_deg[0];
  assign PHASE_OFFSET_DEG_B_O = ph_deg[1];
  assign OP_INIT_A_O = op_init[0];
  assign OP_INIT_B_O = op_init[1];

  // active sync settings come from the power-on copy
  assign LOCK_LOOP_ON_O = {sync_act_q[`SMCB_S_LOCK_B],
                           sync_act_q[`SMCB_S_LOCK_A]};
  assign FREQ_LOOP_ON_O = {sync_act_q[`SMCB_S_FREQ_B],
                           sync_act_q[`SMCB_S_FREQ_A]};
  assign FREQ_LOOP_GAIN_HALF_A_O = sync_act_q[`SMCB_S_GAIN_A];
  assign SYNC_OUT_FROM_B_O = sync_act_q[`SMCB_S_OUT_SEL];
  assign SYNC_CLOCK_INTERNAL_O = {sync_act_q[`SMCB_S_SRC_B],
                                  sync_act_q[`SMCB_S_SRC_A]};

  assign IIN_CALC_REPORT_O   = misc_q[`SMCB_M_IIN_RD];
  assign IIN_CALC_FAULT_EN_O = misc_q[`SMCB_M_IIN_FLT];
  // code 01 A, 10 B, 11 both; 00 selects nothing
  assign IIN_USE_A_O = misc_q[`SMCB_M_IIN_SEL];
  assign IIN_USE_B_O = misc_q[`SMCB_M_IIN_SEL + 1];
  assign DOWN_SLEW_SHIFT_A_O = misc_q[`SMCB_M_DOWN_A +: 2];
  assign DOWN_SLEW_SHIFT_B_O = misc_q[`SMCB_M_DOWN_B +: 2];
  assign FORCE_CHECK_BYTE_O  = misc_q[`SMCB_M_CHECK_BYTE];
  assign BOOT_TARGET_AFTER_SHUTDOWN_O = misc_q[`SMCB_M_BOOT_OSD];
  assign TRIM_RANGE_EXTEND_O = misc_q[`SMCB_M_TRIM];

  assign SYNC_STORE_O  = sync_q;
  assign ADDR_STORE_O  = addr_q;
  assign ACTIVE_ADDR_O = addr_act_q;
  assign VBOOT_A_O     = vboot_q;
  assign PHASE_CFG_O   = phase_cfg_q;

  assign CMD_ACK_O    = ack_q;
  assign CMD_NACK_O   = nack_q;
  assign CMD_RDATA_O  = rdata_q;
  assign DATA_FAULT_O = data_fault_q;
  assign NO_UPDATE_O  = no_update_q;
  assign ALERT_O      = data_fault_q || no_update_q;
endmodule

// File: core/smcb_log_mem.sv
// smcb_log_mem: transaction log storage, one write port, one read port
// assumes: single clock; read data registered, one cycle behind raddr
`timescale 1ns/1ps
module smcb_log_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 64,
  parameter int AW    = 5
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_I,
  input  wire logic             WE_I,
  input  wire logic [AW-1:0]    WADDR_I,
  input  wire logic [WIDTH-1:0] WDATA_I,
  input  wire logic [AW-1:0]    RADDR_I,
  output logic      [WIDTH-1:0] RDATA_O
);
  // no reset on the array: contents before the first write are undefined
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  always_ff @(posedge CLK_I) begin
    if (WE_I) begin
      mem_q[WADDR_I] <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[RADDR_I];
    end
  end

  assign RDATA_O = rdata_q;
endmodule

// File: core/smcb_pkg.sv
// smcb_pkg: types shared by the configuration bank
// assumes: constants come from smcb_regs.svh
package smcb_pkg;

  typedef enum logic [1:0] {
    LL_FORCED_CONT,
    LL_PHASE0_AUTO,
    LL_ALL_AUTO,
    LL_SOFTSTART_AUTO
  } smcb_light_load_t;

  typedef enum logic {
    ST_LOAD,
    ST_RUN
  } smcb_state_t;

endpackage

// File: core/smcb_regs.svh
// smcb_regs.svh: command codes, field positions, masks and limits
// assumes: included by bare name from the configuration bank files
`ifndef SMCB_REGS_SVH
`define SMCB_REGS_SVH

// command codes
`define SMCB_CMD_LOG        8'he0
`define SMCB_CMD_SYNC       8'he4
`define SMCB_CMD_MISC       8'hed
`define SMCB_CMD_OVR        8'hee
`define SMCB_CMD_ADDR       8'hef

// implemented-bit masks; reserved bits read zero
`define SMCB_SYNC_MASK      48'hffff_ffff_dfe0
`define SMCB_MISC_MASK      40'hff_ff00_efff
`define SMCB_OVR_MASK       8'h17
`define SMCB_ADDR_MASK      7'h7f

// sync configuration field positions
`define SMCB_S_SRC_A        5
`define SMCB_S_SRC_B        6
`define SMCB_S_OUT_SEL      7
`define SMCB_S_LOCK_A       8
`define SMCB_S_FREQ_A       9
`define SMCB_S_GAIN_A       10
`define SMCB_S_LOCK_B       11
`define SMCB_S_FREQ_B       12
`define SMCB_S_PWMDIV_A     16
`define SMCB_S_PHASE_A      20
`define SMCB_S_PWMDIV_B     24
`define SMCB_S_PHASE_B      28
`define SMCB_S_SCALAR_B     32
`define SMCB_S_SCALAR_A     35
`define SMCB_S_INDIV        41

// miscellaneous options field positions
`define SMCB_M_VSRC_B       0
`define SMCB_M_VSRC_A       2
`define SMCB_M_BOOT_OSD     4
`define SMCB_M_CHECK_BYTE   5
`define SMCB_M_DOWN_B       8
`define SMCB_M_DOWN_A       10
`define SMCB_M_TRIM         13
`define SMCB_M_LOG_READ_OFFSET      24
`define SMCB_M_IIN_SEL      29
`define SMCB_M_IIN_FLT      31
`define SMCB_M_IIN_RD       32
`define SMCB_M_LL_B         36
`define SMCB_M_LL_A         38

// pin override field positions
`define SMCB_O_BOOT         0
`define SMCB_O_ADDR         1
`define SMCB_O_PHASE        4

// limits and encodings
`define SMCB_PHASE_MAX      4'hc
`define SMCB_PHASE_STEP     9'd30
`define SMCB_PWMDIV_MAX     4'ha
`define SMCB_INDIV_MAX      6'h0f
`define SMCB_SCALAR_BAD     3'h4
`define SMCB_OP_INIT_HI     4'hc
`define SMCB_OP_INIT_LO     4'h0
`define SMCB_LOG_DEPTH      32
`define SMCB_LOG_WIDTH      64

`endif

// File: tb/smcb_bank_props.sv
// smcb_bank_props: command port timing, refusals and flag checks
// assumes: bound to smcb_bank, sees its ports only, one clock domain
`timescale 1ns/1ps
module smcb_bank_props (
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic        CMD_WRITE_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [47:0] CMD_DATA_I,
  input  wire logic        CMD_PEC_I,
  input  wire logic        CMD_ACK_O,
  input  wire logic        CMD_NACK_O,
  input  wire logic        CONVERTING_I,
  input  wire logic        STATUS_CLR_I,
  input  wire logic [47:0] SYNC_STORE_O,
  input  wire logic [6:0]  ACTIVE_ADDR_O,
  input  wire logic        FORCE_CHECK_BYTE_O,
  input  wire logic        DATA_FAULT_O,
  input  wire logic        NO_UPDATE_O,
  input  wire logic        ALERT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // requests in the load cycle get no answer, so they are not counted
  logic live_q;
  logic live2_q;
  logic take;
  logic wr_sync;
  always_ff @(posedge CLK_I) begin
    live_q <= !RESET_I;
  end
  always_ff @(posedge CLK_I) begin
    live2_q <= live_q && !RESET_I;
  end
  assign take    = CMD_VALID_I && live_q;
  assign wr_sync = take && CMD_WRITE_I && CMD_CODE_I == 8'he4 && CMD_PEC_I;

  a_answer_cause: assert property ((CMD_ACK_O || CMD_NACK_O) |->
    $past(CMD_VALID_I)) else $error("answer without request");
  a_one_answer: assert property (take |=> CMD_ACK_O ^ CMD_NACK_O)
    else $error("request not answered once");
  a_conv_refuse: assert property (wr_sync && CONVERTING_I |=>
    CMD_NACK_O && NO_UPDATE_O) else $error("sync write while converting");
  a_phase_refuse: assert property (wr_sync && !CONVERTING_I &&
    CMD_DATA_I[23:20] > 4'hc |=> CMD_NACK_O && DATA_FAULT_O)
    else $error("reserved phase code accepted");
  a_check_byte: assert property (take && FORCE_CHECK_BYTE_O &&
    !CMD_PEC_I |=> CMD_NACK_O) else $error("missing check byte accepted");
  a_unmapped_nack: assert property (take && !(CMD_CODE_I inside
    {8'he0, 8'he4, 8'hed, 8'hee, 8'hef}) |=> CMD_NACK_O)
    else $error("unmapped code accepted");
  a_store_cause: assert property (live2_q &&
    !$stable(SYNC_STORE_O) |-> CMD_ACK_O && $past(CMD_CODE_I) == 8'he4)
    else $error("sync image changed without accepted write");
  a_addr_fixed: assert property (live2_q |->
    $stable(ACTIVE_ADDR_O))
    else $error("active address changed after power-on");
  a_flags_clear: assert property (STATUS_CLR_I && !CMD_VALID_I |=>
    !DATA_FAULT_O && !NO_UPDATE_O) else $error("flags not cleared");
  a_alert_follow: assert property ($rose(DATA_FAULT_O) |->
    ##[0:1] ALERT_O) else $error("alert missing on data fault");

  c_write_ack: cover property (take && CMD_WRITE_I ##1 CMD_ACK_O);
  c_data_fault: cover property ($rose(DATA_FAULT_O));
  c_no_update: cover property ($rose(NO_UPDATE_O));
endmodule

// File: tb/smcb_nvm_model.sv
// smcb_nvm_model: non-volatile store, strap pins and log frame source
// assumes: values stay still across each power-on load; one clock
`timescale 1ns/1ps
module smcb_nvm_model (
  input  wire logic        clk_i,
  input  wire logic        alt_i,
  output logic      [47:0] nvm_sync_o,
  output logic      [39:0] nvm_misc_o,
  output logic      [7:0]  nvm_ovr_o,
  output logic      [6:0]  nvm_addr_o,
  output logic      [7:0]  nvm_vboot_o,
  output logic      [7:0]  nvm_phase_o,
  output logic      [6:0]  pin_addr_o,
  output logic      [7:0]  pin_vboot_o,
  output logic      [7:0]  pin_phase_o,
  output logic             log_we_o,
  output logic      [63:0] log_data_o
);
  // second set hands address and boot to nvm, phase config to pins
  assign nvm_ovr_o   = alt_i ? 8'h10 : 8'h03;
  assign nvm_sync_o  = 48'h0000_c030_15a0;
  assign nvm_misc_o  = 40'h71_4700_2d18;
  assign nvm_addr_o  = 7'h15;
  assign nvm_vboot_o = 8'h42;
  assign nvm_phase_o = 8'h0c;
  assign pin_addr_o  = 7'h2a;
  assign pin_vboot_o = 8'h81;
  assign pin_phase_o = 8'h36;
  initial begin
    log_we_o   = 1'b0;
    log_data_o = 64'h0;
  end
  // data is inverted once released so a stale frame never looks valid
  task automatic push(input logic [63:0] d);
    @(posedge clk_i);
    log_we_o   <= 1'b1;
    log_data_o <= d;
    @(posedge clk_i);
    log_we_o   <= 1'b0;
    log_data_o <= ~d;
  endtask
endmodule

// File: tb/tb_smcb_bank.sv
// tb_smcb_bank: directed scenarios for the configuration command bank
// assumes: smcb_bank, its checker and the nvm model are compiled first
`timescale 1ns/1ps
module tb_smcb_bank;
  logic        CLK_I, RESET_I, CMD_VALID_I, CMD_WRITE_I, CMD_PEC_I;
  logic        CONVERTING_I, STATUS_CLR_I, LOG_WE_I, alt;
  logic        CMD_ACK_O, CMD_NACK_O, DATA_FAULT_O, NO_UPDATE_O, ALERT_O;
  logic        FREQ_LOOP_GAIN_HALF_A_O, SYNC_OUT_FROM_B_O, IIN_USE_A_O;
  logic        IIN_CALC_REPORT_O, IIN_CALC_FAULT_EN_O, IIN_USE_B_O;
  logic        FORCE_CHECK_BYTE_O, BOOT_TARGET_AFTER_SHUTDOWN_O;
  logic        TRIM_RANGE_EXTEND_O;
  logic [7:0]  CMD_CODE_I, NVM_OVR_I, NVM_VBOOT_A_I, NVM_PHASE_CFG_I;
  logic [7:0]  PIN_VBOOT_A_I, PIN_PHASE_CFG_I, VBOOT_A_O, PHASE_CFG_O;
  logic [47:0] CMD_DATA_I, NVM_SYNC_I, SYNC_STORE_O;
  logic [39:0] NVM_MISC_I;
  logic [6:0]  NVM_ADDR_I, PIN_ADDR_I, ADDR_STORE_O, ACTIVE_ADDR_O;
  logic [63:0] CMD_RDATA_O, LOG_DATA_I;
  logic [1:0]  SOFT_START_I, LOCK_LOOP_ON_O, FREQ_LOOP_ON_O;
  logic [1:0]  SYNC_CLOCK_INTERNAL_O, DCM_ALL_O, DCM_PHASE0_O;
  logic [1:0]  DOWN_SLEW_SHIFT_A_O, DOWN_SLEW_SHIFT_B_O;
  logic [8:0]  PHASE_OFFSET_DEG_A_O, PHASE_OFFSET_DEG_B_O;
  logic [3:0]  OP_INIT_A_O, OP_INIT_B_O;
  int          err_count = 0;
  int          checks = 0;

  smcb_bank u_smcb_bank (.CLK_I, .RESET_I, .CMD_VALID_I, .CMD_WRITE_I,
    .CMD_CODE_I, .CMD_DATA_I, .CMD_PEC_I, .CMD_ACK_O, .CMD_NACK_O,
    .CMD_RDATA_O, .CONVERTING_I, .STATUS_CLR_I, .NVM_SYNC_I, .NVM_MISC_I,
    .NVM_OVR_I, .NVM_ADDR_I, .NVM_VBOOT_A_I, .NVM_PHASE_CFG_I, .PIN_ADDR_I,
    .PIN_VBOOT_A_I, .PIN_PHASE_CFG_I, .LOG_WE_I, .LOG_DATA_I, .SOFT_START_I,
    .SYNC_STORE_O, .ADDR_STORE_O, .ACTIVE_ADDR_O, .VBOOT_A_O, .PHASE_CFG_O,
    .LOCK_LOOP_ON_O, .FREQ_LOOP_ON_O, .FREQ_LOOP_GAIN_HALF_A_O,
    .SYNC_OUT_FROM_B_O, .SYNC_CLOCK_INTERNAL_O, .PHASE_OFFSET_DEG_A_O,
    .PHASE_OFFSET_DEG_B_O, .DCM_ALL_O, .DCM_PHASE0_O, .IIN_CALC_REPORT_O,
    .IIN_CALC_FAULT_EN_O, .IIN_USE_A_O, .IIN_USE_B_O, .DOWN_SLEW_SHIFT_A_O,
    .DOWN_SLEW_SHIFT_B_O, .FORCE_CHECK_BYTE_O, .BOOT_TARGET_AFTER_SHUTDOWN_O,
    .TRIM_RANGE_EXTEND_O, .OP_INIT_A_O, .OP_INIT_B_O, .DATA_FAULT_O,
    .NO_UPDATE_O, .ALERT_O);

  smcb_nvm_model u_smcb_nvm_model (.clk_i(CLK_I), .alt_i(alt),
    .nvm_sync_o(NVM_SYNC_I), .nvm_misc_o(NVM_MISC_I), .nvm_ovr_o(NVM_OVR_I),
    .nvm_addr_o(NVM_ADDR_I), .nvm_vboot_o(NVM_VBOOT_A_I),
    .nvm_phase_o(NVM_PHASE_CFG_I), .pin_addr_o(PIN_ADDR_I),
    .pin_vboot_o(PIN_VBOOT_A_I), .pin_phase_o(PIN_PHASE_CFG_I),
    .log_we_o(LOG_WE_I), .log_data_o(LOG_DATA_I));

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // one command, one cycle of strobe; answer is due one edge later
  task automatic cmd(input logic w, input logic [7:0] c,
                     input logic [47:0] d, input logic p, input logic ea);
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b1;
    CMD_WRITE_I <= w;
    CMD_CODE_I  <= c;
    CMD_DATA_I  <= d;
    CMD_PEC_I   <= p;
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b0;
    CMD_DATA_I  <= ~d;
    #1;
    chk(CMD_ACK_O === ea && CMD_NACK_O === !ea, "answer");
  endtask

  task automatic rd(input logic [7:0] c, input logic [63:0] e);
    cmd(1'b0, c, 48'h0, 1'b1, 1'b1);
    chk(CMD_RDATA_O === e, "read data");
  endtask

  task automatic s_load_decode;
    chk(LOCK_LOOP_ON_O === 2'b01, "lock loop");
    chk(FREQ_LOOP_ON_O === 2'b10, "freq loop");
    chk(FREQ_LOOP_GAIN_HALF_A_O === 1'b1, "gain");
    chk(SYNC_OUT_FROM_B_O === 1'b1, "sync out");
    chk(SYNC_CLOCK_INTERNAL_O === 2'b01, "clock source");
    chk(PHASE_OFFSET_DEG_A_O === 9'd90, "phase a");
    chk(PHASE_OFFSET_DEG_B_O === 9'd360, "phase b");
    chk(DCM_ALL_O === 2'b00 && DCM_PHASE0_O === 2'b01,
        "light load");
    @(posedge CLK_I);
    SOFT_START_I <= 2'b10;
    @(posedge CLK_I);
    #1;
    chk(DCM_ALL_O === 2'b10 && DCM_PHASE0_O === 2'b11,
        "soft start");
    chk(IIN_CALC_REPORT_O === 1'b1, "iin report");
    chk(IIN_CALC_FAULT_EN_O === 1'b0, "iin fault");
    chk(IIN_USE_A_O === 1'b0 && IIN_USE_B_O === 1'b1, "iin sel");
    chk(DOWN_SLEW_SHIFT_A_O === 2'b11, "down a");
    chk(DOWN_SLEW_SHIFT_B_O === 2'b01, "down b");
    chk(BOOT_TARGET_AFTER_SHUTDOWN_O === 1'b1, "boot target");
    chk(OP_INIT_A_O === 4'hc && OP_INIT_B_O === 4'h0, "op init");
    chk(TRIM_RANGE_EXTEND_O === 1'b1, "trim extend");
    chk(ACTIVE_ADDR_O === 7'h2a && VBOOT_A_O === 8'h81,
        "pins");
    chk(PHASE_CFG_O === 8'h0c, "phase config");
    rd(8'hed, 64'h71_4000_2d18);
    rd(8'he4, 64'h0000_c030_15a0);
  endtask

  task automatic s_sync_writes;
    logic [47:0] bad [5];
    bad = '{48'h0000_000b_0000, 48'h0000_0b00_0000, 48'h0004_0000_0000,
            48'h0020_0000_0000, 48'h2000_0000_0000};
    cmd(1'b1, 8'he4, 48'h0000_5a40_3aff, 1'b1, 1'b1);
    chk(SYNC_STORE_O === 48'h0000_5a40_1ae0, "sync image");
    chk(LOCK_LOOP_ON_O === 2'b01, "active sync kept");
    for (int i = 0; i < 16; i++) begin
      cmd(1'b1, 8'he4, {24'h0, i[3:0], 20'h0}, 1'b1, i < 13);
    end
    foreach (bad[i]) begin
      cmd(1'b1, 8'he4, bad[i], 1'b1, 1'b0);
    end
    chk(SYNC_STORE_O === 48'h0000_00c0_0000, "refused kept");
    chk(DATA_FAULT_O === 1'b1 && ALERT_O === 1'b1, "fault flag");
    @(posedge CLK_I);
    CONVERTING_I <= 1'b1;
    cmd(1'b1, 8'he4, 48'h0, 1'b1, 1'b0);
    chk(NO_UPDATE_O === 1'b1, "no update flag");
    chk(SYNC_STORE_O === 48'h0000_00c0_0000, "converting kept");
    @(posedge CLK_I);
    CONVERTING_I <= 1'b0;
    STATUS_CLR_I <= 1'b1;
    @(posedge CLK_I);
    STATUS_CLR_I <= 1'b0;
    #1;
    chk(DATA_FAULT_O === 1'b0 && NO_UPDATE_O === 1'b0,
        "flags clear");
  endtask

  task automatic s_log_check;
    for (int i = 0; i < 3; i++) begin
      u_smcb_nvm_model.push(64'h5aa5_0000_0000_0000 | i);
    end
    cmd(1'b1, 8'hed, 48'h80_8200_0020, 1'b1, 1'b1);
    chk(FORCE_CHECK_BYTE_O === 1'b1, "check byte on");
    chk(IIN_CALC_FAULT_EN_O === 1'b1, "iin fault on");
    chk(IIN_CALC_REPORT_O === 1'b0, "iin sensed");
    chk(IIN_USE_A_O === 1'b0 && IIN_USE_B_O === 1'b0, "iin none");
    chk(DCM_ALL_O === 2'b01 && DCM_PHASE0_O === 2'b01,
        "light load all");
    chk(DOWN_SLEW_SHIFT_A_O === 2'b00, "down a full");
    chk(BOOT_TARGET_AFTER_SHUTDOWN_O === 1'b0, "target kept");
    chk(OP_INIT_A_O === 4'h0, "op init a zero");
    cmd(1'b0, 8'hed, 48'h0, 1'b0, 1'b0);
    rd(8'he0, 64'h5aa5_0000_0000_0002);
    cmd(1'b1, 8'he0, 48'h0, 1'b1, 1'b0);
  endtask

  task automatic s_ovr_addr;
    cmd(1'b1, 8'hee, 48'hff, 1'b1, 1'b1);
    chk(VBOOT_A_O === 8'h81 && PHASE_CFG_O === 8'h0c,
        "no redetect");
    rd(8'hee, 64'h17);
    cmd(1'b1, 8'hef, 48'hff, 1'b1, 1'b1);
    chk(ADDR_STORE_O === 7'h7f, "address image");
    chk(ACTIVE_ADDR_O === 7'h2a, "old address kept");
    rd(8'hef, 64'h7f);
    cmd(1'b1, 8'h55, 48'h0, 1'b1, 1'b0);
  endtask

  // overrides written above are lost; at power-on address and boot now come from nvm, phase config from pins
  task automatic s_second_reset;
    @(posedge CLK_I);
    RESET_I <= 1'b1;
    alt     <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    #1;
    chk(ACTIVE_ADDR_O === 7'h15 && VBOOT_A_O === 8'h42,
        "nvm set");
    chk(PHASE_CFG_O === 8'h36, "phase from pin");
    rd(8'hed, 64'h71_4000_2d18);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end

  initial begin
    RESET_I = 1'b1;
    alt = 1'b0;
    CMD_VALID_I = 1'b0;
    CMD_WRITE_I = 1'b0;
    CMD_CODE_I = 8'h00;
    CMD_DATA_I = 48'h0;
    CMD_PEC_I = 1'b0;
    CONVERTING_I = 1'b0;
    STATUS_CLR_I = 1'b0;
    SOFT_START_I = 2'b00;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    #1;
    s_load_decode;
    s_sync_writes;
    s_log_check;
    s_ovr_addr;
    s_second_reset;
    final_report;
  end

  initial begin
    #200000;
    err_count++;
    final_report;
  end
endmodule

bind smcb_bank smcb_bank_props u_smcb_bank_props (.CLK_I, .RESET_I,
  .CMD_VALID_I, .CMD_WRITE_I, .CMD_CODE_I, .CMD_DATA_I, .CMD_PEC_I,
  .CMD_ACK_O, .CMD_NACK_O, .CONVERTING_I, .STATUS_CLR_I, .SYNC_STORE_O,
  .ACTIVE_ADDR_O, .FORCE_CHECK_BYTE_O, .DATA_FAULT_O, .NO_UPDATE_O,
  .ALERT_O);
